// File: design/dtc_pkg.sv
package dtc_pkg;

    // ==========================================================
    // register map (byte addresses)
    localparam logic [7:0] OFS_CTRL  = 8'h00;
    localparam logic [7:0] OFS_STAT  = 8'h04;
    localparam logic [7:0] OFS_SRC   = 8'h08;
    localparam logic [7:0] OFS_DST   = 8'h0C;
    localparam logic [7:0] OFS_CNT   = 8'h10;
    localparam logic [7:0] OFS_FC    = 8'h14;

    // ==========================================================
    // channel_control fields
    localparam int B_GO     = 0;
    localparam int B_REQ    = 1;
    localparam int B_SHARE  = 3;
    localparam int B_SSZ    = 5;
    localparam int B_DSZ    = 6;
    localparam int B_SINC   = 7;
    localparam int B_DINC   = 8;
    localparam int B_BUS16  = 9;
    localparam int B_BUS_CLEAR_ON_INTERRUPT_ENABLE   = 10;
    localparam int B_ECO    = 11;
    localparam int B_NORMAL_END_IRQ_ENABLE   = 12;
    localparam int B_ERROR_IRQ_ENABLE   = 13;
    localparam int B_SRST   = 14;
    localparam int B_DEVSRC = 15;
    localparam int CTRL_W   = 16;

    // ==========================================================
    // channel_status fields
    localparam int B_DONE   = 0;
    localparam int B_SERR   = 1;
    localparam int B_DERR   = 2;
    localparam int B_DNS    = 3;
    localparam int B_ACTIVE = 4;

    // ==========================================================
    // reset values
    localparam logic [15:0] CTRL_RST = 16'h0000;
    localparam logic [3:0]  STAT_RST = 4'h0;
    localparam logic [15:0] CNT_RST  = 16'h0000;
    localparam logic [7:0]  FC_RST   = 8'h00;

    // ==========================================================
    // limited-rate window and shares (clocks of bus use per window)
    localparam int          WINDOW_CLKS = 1024;
    localparam logic [10:0] SHARE_12P5  = 11'h080;
    localparam logic [10:0] SHARE_25    = 11'h100;
    localparam logic [10:0] SHARE_50    = 11'h200;
    localparam logic [10:0] SHARE_75    = 11'h300;

    typedef enum logic [1:0] {
        REQ_INT_MAX   = 2'b00,
        REQ_INT_LIM   = 2'b01,
        REQ_EXT_BURST = 2'b10,
        REQ_EXT_STEAL = 2'b11
    } dtc_reqgen_type;

    typedef enum logic [1:0] {
        S_IDLE  = 2'b00,
        S_READ  = 2'b01,
        S_WRITE = 2'b10
    } dtc_state_type;

endpackage

// File: design/dtc_channel.sv
`timescale 1ns/1ps
module dtc_channel #(
    parameter int AW = 24
) (
    input  wire logic          sys_clk_i,
    input  wire logic          rst_i,
    input  wire logic          psel_i,
    input  wire logic          penable_i,
    input  wire logic          pwrite_i,
    input  wire logic [7:0]    paddr_i,
    input  wire logic [31:0]   pwdata_i,
    output logic      [31:0]   prdata_o,
    output logic               pready_o,
    output logic               pslverr_o,
    output logic               mbus_req_o,
    output logic               mbus_wr_o,
    output logic               mbus_word_o,
    output logic      [AW-1:0] mbus_addr_o,
    output logic      [2:0]    mbus_fc_o,
    output logic      [15:0]   mbus_wdata_o,
    input  wire logic [15:0]   mbus_rdata_i,
    input  wire logic          mbus_ack_i,
    input  wire logic          mbus_err_i,
    output logic               bus_own_o,
    input  wire logic          bus_request_i,
    input  wire logic          core_irq_i,
    input  wire logic          periph_request_n_i,
    output logic               periph_acknowledge_n_o,
    input  wire logic          done_n_i,
    output logic               done_n_o,
    output logic               done_oe_o,
    output logic               irq_normal_o,
    output logic               irq_error_o
);

    // ==========================================================
    // cycle planning
    // returns {two cycles, byte cycles, step of two between them}
    function automatic logic [2:0] plan_f(input logic bus16, input logic self_w,
                                          input logic other_w, input logic a0);
        logic [2:0] p;
        p = 3'b000;
        if (!bus16)
            p = 3'b010;
        else if (!self_w && other_w)
            p = 3'b111;
        else if (!self_w)
            p = 3'b010;
        else if (a0)
            p = 3'b110;
        return p;
    endfunction

    function automatic logic [2:0] inc_f(input logic bus16, input logic self_w,
                                         input logic other_w);
        logic [2:0] v;
        v = 3'h1;
        if (bus16 && !self_w && other_w)
            v = 3'h4;
        else if (bus16 && self_w)
            v = 3'h2;
        return v;
    endfunction

    // ==========================================================
    // state
    dtc_pkg::dtc_state_type state_reg, nx_state;
    logic                   idx_reg, nx_idx;
    logic [15:0]            ctrl_reg;
    logic [3:0]             stat_reg;
    logic [AW-1:0]          src_reg, dst_reg;
    logic [15:0]            cnt_reg;
    logic [7:0]             fc_reg;
    logic [15:0]            dhr_reg;
    logic                   last_reg, pend_reg, ack_seen_reg, done_seen_reg;
    logic                   on_dev_reg, last_side_reg, req_n_prev_reg;
    logic [9:0]             win_reg;
    logic [10:0]            used_reg;
    logic                   pready_reg;

    wire go     = ctrl_reg[dtc_pkg::B_GO];
    wire [1:0] mode = ctrl_reg[dtc_pkg::B_REQ +: 2];
    wire ext    = mode[1];
    wire ssz    = ctrl_reg[dtc_pkg::B_SSZ];
    wire dsz    = ctrl_reg[dtc_pkg::B_DSZ];
    wire bus16  = ctrl_reg[dtc_pkg::B_BUS16];
    wire idle   = (state_reg == dtc_pkg::S_IDLE);
    wire locked = go || !idle;

    wire [2:0] s_plan = plan_f(bus16, ssz, dsz, src_reg[0]);
    wire [2:0] d_plan = plan_f(bus16, dsz, ssz, dst_reg[0]);
    wire [2:0] s_inc  = inc_f(bus16, ssz, dsz);
    wire [2:0] d_inc  = inc_f(bus16, dsz, ssz);
    wire [1:0] op_bytes = (bus16 && (ssz || dsz)) ? 2'h2 : 2'h1;
    wire [15:0] cnt_dec = cnt_reg - {14'h0000, op_bytes};

    // ==========================================================
    // register bus decode
    wire acc    = psel_i && penable_i && pready_reg;
    wire wr_en  = acc && pwrite_i;
    wire w_ctrl = wr_en && (paddr_i == dtc_pkg::OFS_CTRL);
    wire w_stat = wr_en && (paddr_i == dtc_pkg::OFS_STAT);
    wire w_src  = wr_en && (paddr_i == dtc_pkg::OFS_SRC) && !locked;
    wire w_dst  = wr_en && (paddr_i == dtc_pkg::OFS_DST) && !locked;
    wire w_cnt  = wr_en && (paddr_i == dtc_pkg::OFS_CNT) && !locked;
    wire w_fc   = wr_en && (paddr_i == dtc_pkg::OFS_FC) && !locked;
    wire srst   = w_ctrl && pwdata_i[dtc_pkg::B_SRST];
    wire mapped = (paddr_i == dtc_pkg::OFS_CTRL) || (paddr_i == dtc_pkg::OFS_STAT)
               || (paddr_i == dtc_pkg::OFS_SRC) || (paddr_i == dtc_pkg::OFS_DST)
               || (paddr_i == dtc_pkg::OFS_CNT) || (paddr_i == dtc_pkg::OFS_FC);
    wire [31:0] rd_mux =
        (paddr_i == dtc_pkg::OFS_CTRL) ? {16'h0000, ctrl_reg} :
        (paddr_i == dtc_pkg::OFS_STAT) ? {27'h0000000, !idle, stat_reg} :
        (paddr_i == dtc_pkg::OFS_SRC)  ? {{(32-AW){1'b0}}, src_reg} :
        (paddr_i == dtc_pkg::OFS_DST)  ? {{(32-AW){1'b0}}, dst_reg} :
        (paddr_i == dtc_pkg::OFS_CNT)  ? {16'h0000, cnt_reg} :
        (paddr_i == dtc_pkg::OFS_FC)   ? {24'h000000, fc_reg} : 32'h00000000;

    // ==========================================================
    // request generation
    wire req_low  = !periph_request_n_i;
    wire req_fall = req_n_prev_reg && req_low;
    wire yield    = !ext && (bus_request_i
                  || (core_irq_i && ctrl_reg[dtc_pkg::B_BUS_CLEAR_ON_INTERRUPT_ENABLE]));
    wire [10:0] quota =
        (ctrl_reg[dtc_pkg::B_SHARE +: 2] == 2'b00) ? dtc_pkg::SHARE_12P5 :
        (ctrl_reg[dtc_pkg::B_SHARE +: 2] == 2'b01) ? dtc_pkg::SHARE_25 :
        (ctrl_reg[dtc_pkg::B_SHARE +: 2] == 2'b10) ? dtc_pkg::SHARE_50 : dtc_pkg::SHARE_75;
    wire quota_ok = (mode != dtc_pkg::REQ_INT_LIM) || (used_reg < quota);
    // go checked only between operands, so clearing it lets one finish
    wire start_ok = idle && go && (!ext || pend_reg) && !yield
                  && quota_ok && !srst;
    wire fin_dev_ack = mbus_ack_i && !idle && on_dev_reg && last_side_reg;
    wire burst_pend = start_ok ? 1'b0 :
                      (fin_dev_ack || idle) ? (go && req_low) : pend_reg;
    wire steal_pend = start_ok ? 1'b0 :
                      (go && req_fall && (idle || ack_seen_reg)) ? 1'b1 :
                      pend_reg;
    wire pend_next  = (mode == dtc_pkg::REQ_EXT_STEAL) ? steal_pend : burst_pend;

    // ==========================================================
    // operand sequencer
    wire rd_two  = s_plan[2];
    wire wr_two  = d_plan[2];
    wire bus_err = !idle && mbus_err_i;
    wire op_end  = (state_reg == dtc_pkg::S_WRITE) && mbus_ack_i && !mbus_err_i
                 && (!wr_two || idx_reg);
    wire done_hit = done_seen_reg || (mbus_ack_i && on_dev_reg && !done_n_i
                  && !done_oe_o);
    wire term_norm = op_end && ((cnt_dec == 16'h0000) || done_hit);

    always_comb begin
        nx_state = state_reg;
        nx_idx   = idx_reg;
        unique case (state_reg)
            dtc_pkg::S_IDLE: begin
                if (start_ok) begin
                    nx_state = dtc_pkg::S_READ;
                    nx_idx   = 1'b0;
                end
            end
            dtc_pkg::S_READ: begin
                if (mbus_err_i) begin
                    nx_state = dtc_pkg::S_IDLE;
                end else if (mbus_ack_i && rd_two && !idx_reg) begin
                    nx_idx = 1'b1;
                end else if (mbus_ack_i) begin
                    nx_state = dtc_pkg::S_WRITE;
                    nx_idx   = 1'b0;
                end
            end
            dtc_pkg::S_WRITE: begin
                if (mbus_err_i || op_end) begin
                    nx_state = dtc_pkg::S_IDLE;
                end else if (mbus_ack_i) begin
                    nx_idx = 1'b1;
                end
            end
            default: nx_state = dtc_pkg::S_IDLE;
        endcase
        if (srst) begin
            nx_state = dtc_pkg::S_IDLE;
        end
    end

    // next bus cycle parameters
    wire nx_busy = (nx_state != dtc_pkg::S_IDLE);
    wire nx_rd   = (nx_state == dtc_pkg::S_READ);
    wire [1:0] off = (nx_rd ? s_plan[0] : d_plan[0]) ? {nx_idx, 1'b0} : {1'b0, nx_idx};
    wire [AW-1:0] addr_next = (nx_rd ? src_reg : dst_reg) + {{(AW-2){1'b0}}, off};
    wire [15:0] dhr_next =
        !(mbus_ack_i && state_reg == dtc_pkg::S_READ) ? dhr_reg :
        !s_plan[1] ? mbus_rdata_i :
        (rd_two && !idx_reg) ? {mbus_rdata_i[7:0], dhr_reg[7:0]} :
        {dhr_reg[15:8], mbus_rdata_i[7:0]};
    wire [15:0] wdata_next = !d_plan[1] ? dhr_next :
        {8'h00, (wr_two && !nx_idx) ? dhr_next[15:8] : dhr_next[7:0]};
    wire dev_side_rd = ext ? ctrl_reg[dtc_pkg::B_DEVSRC] : !ctrl_reg[dtc_pkg::B_ECO];
    wire nx_on_dev   = nx_busy && (nx_rd == dev_side_rd);
    wire nx_last_sd  = nx_rd ? (!rd_two || nx_idx) : (!wr_two || nx_idx);
    wire last_now    = idle ? ((cnt_reg != 16'h0000) && (cnt_reg <= {14'h0000, op_bytes}))
                     : last_reg;
    wire drive_done  = last_now && nx_on_dev && nx_last_sd;
    wire [AW-1:0] src_step = {{(AW-3){1'b0}}, s_inc};
    wire [AW-1:0] dst_step = {{(AW-3){1'b0}}, d_inc};

    // ==========================================================
    // registers
    wire [3:0] stat_set = {term_norm && done_hit && !(cnt_dec == 16'h0000),
                           bus_err && (state_reg == dtc_pkg::S_WRITE),
                           bus_err && (state_reg == dtc_pkg::S_READ),
                           term_norm};
    wire [3:0] stat_clr = srst ? 4'hF : (w_stat ? pwdata_i[3:0] : 4'h0);
    wire [15:0] ctrl_next =
        w_ctrl ? (pwdata_i[15:0] & ~(16'h0001 << dtc_pkg::B_SRST)
                 & ~({15'h0000, srst} << dtc_pkg::B_GO)) :
        (term_norm || bus_err) ? (ctrl_reg & ~(16'h0001 << dtc_pkg::B_GO)) :
        ctrl_reg;

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            ctrl_reg   <= dtc_pkg::CTRL_RST;
            stat_reg   <= dtc_pkg::STAT_RST;
            pready_reg <= 1'b0;
            prdata_o   <= 32'h00000000;
            pslverr_o  <= 1'b0;
        end else begin
            ctrl_reg   <= ctrl_next;
            stat_reg   <= stat_set | (stat_reg & ~stat_clr);
            pready_reg <= psel_i && !penable_i;
            prdata_o   <= (psel_i && !penable_i) ? rd_mux : prdata_o;
            pslverr_o  <= psel_i && !penable_i && !mapped;
        end
    end
    assign pready_o = pready_reg;

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            src_reg <= '0;
            dst_reg <= '0;
            cnt_reg <= dtc_pkg::CNT_RST;
            fc_reg  <= dtc_pkg::FC_RST;
        end else begin
            if (w_src) src_reg <= pwdata_i[AW-1:0];
            else if (op_end && ctrl_reg[dtc_pkg::B_SINC]) src_reg <= src_reg + src_step;
            if (w_dst) dst_reg <= pwdata_i[AW-1:0];
            else if (op_end && ctrl_reg[dtc_pkg::B_DINC]) dst_reg <= dst_reg + dst_step;
            if (w_cnt) cnt_reg <= pwdata_i[15:0];
            else if (op_end) cnt_reg <= cnt_dec;
            if (w_fc) fc_reg <= pwdata_i[7:0];
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_reg      <= dtc_pkg::S_IDLE;
            idx_reg        <= 1'b0;
            dhr_reg        <= 16'h0000;
            last_reg       <= 1'b0;
            pend_reg       <= 1'b0;
            req_n_prev_reg <= 1'b1;
        end else begin
            state_reg      <= nx_state;
            idx_reg        <= nx_idx;
            dhr_reg        <= dhr_next;
            last_reg       <= last_now;
            pend_reg       <= pend_next;
            req_n_prev_reg <= periph_request_n_i;
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            ack_seen_reg  <= 1'b0;
            done_seen_reg <= 1'b0;
            on_dev_reg    <= 1'b0;
            last_side_reg <= 1'b0;
        end else begin
            ack_seen_reg  <= !start_ok && (ack_seen_reg || !periph_acknowledge_n_o);
            done_seen_reg <= !start_ok && !idle && done_hit;
            on_dev_reg    <= nx_on_dev;
            last_side_reg <= nx_last_sd;
        end
    end

    // bus-owned clocks per window; allotment used means no new operand
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            win_reg  <= 10'h000;
            used_reg <= 11'h000;
        end else begin
            win_reg  <= win_reg + 10'h001;
            used_reg <= (&win_reg) ? 11'h000 : used_reg + {10'h000, !idle};
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            mbus_req_o             <= 1'b0;
            mbus_wr_o              <= 1'b0;
            mbus_word_o            <= 1'b0;
            mbus_addr_o            <= '0;
            mbus_fc_o              <= 3'h0;
            mbus_wdata_o           <= 16'h0000;
            bus_own_o              <= 1'b0;
            periph_acknowledge_n_o <= 1'b1;
            done_n_o               <= 1'b1;
            done_oe_o              <= 1'b0;
            irq_normal_o           <= 1'b0;
            irq_error_o            <= 1'b0;
        end else begin
            mbus_req_o             <= nx_busy;
            mbus_wr_o              <= (nx_state == dtc_pkg::S_WRITE);
            mbus_word_o            <= nx_rd ? !s_plan[1] : !d_plan[1];
            mbus_addr_o            <= addr_next;
            mbus_fc_o              <= nx_rd ? fc_reg[2:0] : fc_reg[6:4];
            mbus_wdata_o           <= wdata_next;
            bus_own_o              <= nx_busy;
            periph_acknowledge_n_o <= !(ext && nx_on_dev);
            done_n_o               <= !drive_done;
            done_oe_o              <= drive_done;
            irq_normal_o <= term_norm && ctrl_reg[dtc_pkg::B_NORMAL_END_IRQ_ENABLE];
            irq_error_o  <= bus_err && ctrl_reg[dtc_pkg::B_ERROR_IRQ_ENABLE];
        end
    end

    // ==========================================================
    // assertions
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);

    sequence seq_rd_err;
        (state_reg == dtc_pkg::S_READ) && mbus_err_i && !srst;
    endsequence
    sequence seq_op_end8;
        op_end && !bus16 && ctrl_reg[dtc_pkg::B_SINC] && !w_src;
    endsequence

    a_ack_on_dev: assert property (!periph_acknowledge_n_o |-> mbus_req_o && ext)
        else $error("acknowledge outside a peripheral access");
    a_start_go: assert property ($rose(mbus_req_o) |-> $past(go))
        else $error("bus cycle began without go");
    a_err_stop: assert property (bus_err && !w_ctrl |=> !go && !mbus_req_o)
        else $error("bus error did not stop channel");
    a_src_err_flag: assert property (seq_rd_err |=> stat_reg[dtc_pkg::B_SERR])
        else $error("read error did not set source flag");
    a_err_irq: assert property (bus_err |=> irq_error_o == $past(ctrl_reg[dtc_pkg::B_ERROR_IRQ_ENABLE]))
        else $error("error event output wrong");
    a_byte_bus_inc: assert property (seq_op_end8 |=> src_reg == $past(src_reg) + 24'h1)
        else $error("8-bit bus pointer step wrong");
    a_lock_regs: assert property (locked && !op_end |=> $stable(cnt_reg) && $stable(src_reg))
        else $error("locked register changed");
    a_yield_hold: assert property (idle && yield |=> idle)
        else $error("started operand while bus clear asserted");
    a_quota_hold: assert property (idle && mode == dtc_pkg::REQ_INT_LIM
        && used_reg >= quota && !(&win_reg) |=> idle)
        else $error("limited rate exceeded allotment");
    a_end_irq: assert property (term_norm && !w_ctrl |=> !go
        && irq_normal_o == $past(ctrl_reg[dtc_pkg::B_NORMAL_END_IRQ_ENABLE]))
        else $error("normal termination handled wrongly");

endmodule // dtc_channel

// File: test/dtc_mem_model.sv
`timescale 1ns/1ps
// ==========================================
// memory bus partner: acks after a set wait, may fail reads
module dtc_mem_model (
    input  wire logic        sys_clk_i,
    input  wire logic        rst_i,
    input  wire logic        req_i,
    input  wire logic        wr_i,
    input  wire logic [23:0] addr_i,
    input  wire logic [3:0]  wait_i,
    input  wire logic        err_en_i,
    output logic             ack_o,
    output logic             err_o,
    output logic      [15:0] rdata_o,
    input  wire logic        preq_en_i,
    input  wire logic        pdone_en_i,
    input  wire logic        pack_n_i,
    output logic             preq_n_o,
    output logic             pdone_n_o
);
    logic [3:0] cnt_reg;
    logic       done_reg;
    // data only valid with ack or err; otherwise inverted so stale values never match
    assign rdata_o = done_reg ? {addr_i[7:0], ~addr_i[7:0]} : {~addr_i[7:0], addr_i[7:0]};
    assign ack_o   = done_reg & ~(err_en_i & ~wr_i);
    assign err_o   = done_reg & err_en_i & ~wr_i;
    // peripheral side: request held low as a level while enabled
    assign preq_n_o  = ~preq_en_i;
    // done shown only while the channel acknowledges a device access
    assign pdone_n_o = ~(pdone_en_i & ~pack_n_i);
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_reg  <= 4'h0;
            done_reg <= 1'b0;
        end else if (done_reg || !req_i) begin
            cnt_reg  <= 4'h0;
            done_reg <= 1'b0;
        end else begin
            cnt_reg  <= cnt_reg + 4'h1;
            done_reg <= (cnt_reg >= wait_i);
        end
    end
endmodule // dtc_mem_model

// File: test/dtc_channel_bench.sv
`timescale 1ns/1ps
module dtc_channel_bench;
    logic sys_clk_i = 0, rst_i = 1, psel = 0, penable = 0, pwrite = 0, req, wr, ack, err, erren = 0;
    logic slverr, e, wword, own, ackn, donen, doe, preqn, pdonen, preq_en = 0, pdone_en = 0;
    logic breq = 0;
    logic [2:0]  fc;
    logic [19:0] wlast = 20'h0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic [23:0] addr;
    logic [15:0] rdata, wdata;
    logic [3:0]  wt = 4'h0;
    logic        pready, irqn, irqe;
    int mismatches = 0, num_checks = 0, nirq = 0, eirq = 0, nack = 0, ndone = 0, cyc = 0;
    always #10 sys_clk_i = ~sys_clk_i;
    always @(posedge sys_clk_i) begin
        nirq <= nirq + int'(irqn === 1'b1);
        eirq <= eirq + int'(irqe === 1'b1);
        nack  <= nack + int'(ackn === 1'b0 && ack === 1'b1);
        ndone <= ndone + int'(doe === 1'b1 && donen === 1'b0 && ack === 1'b1);
        // outside master asks for the bus now and then; internal modes must wait
        cyc   <= cyc + 1;
        breq  <= (cyc[5:3] == 3'h0);
        if (req === 1'b1 && wr === 1'b1 && ack === 1'b1 && own === 1'b1) begin
            wlast <= {fc, wword, wdata};
        end
    end
    dtc_channel i_dtc_channel (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(slverr), .mbus_req_o(req),
        .mbus_wr_o(wr), .mbus_word_o(wword), .mbus_addr_o(addr), .mbus_fc_o(fc),
        .mbus_wdata_o(wdata), .mbus_rdata_i(rdata), .mbus_ack_i(ack), .mbus_err_i(err),
        .bus_own_o(own), .bus_request_i(breq), .core_irq_i(1'b0), .periph_request_n_i(preqn),
        .periph_acknowledge_n_o(ackn), .done_n_i(pdonen), .done_n_o(donen), .done_oe_o(doe),
        .irq_normal_o(irqn), .irq_error_o(irqe));
    dtc_mem_model i_dtc_mem_model (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .req_i(req),
        .wr_i(wr), .addr_i(addr), .wait_i(wt), .err_en_i(erren), .ack_o(ack), .err_o(err),
        .rdata_o(rdata), .preq_en_i(preq_en), .pdone_en_i(pdone_en), .pack_n_i(ackn),
        .preq_n_o(preqn), .pdone_n_o(pdonen));
    // ==========================================
    // apb master and checks
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk_i);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge sys_clk_i);
        penable <= 1'b1;
        @(posedge sys_clk_i);
        while (pready !== 1'b1) @(posedge sys_clk_i);
        q = prdata;
        e = slverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(q, exp);
    endtask
    // start a block and wait until go clears; a write to src in flight must be ignored
    task automatic run(input logic [15:0] ctrl, input logic [15:0] cnt);
        apb(1'b1, dtc_pkg::OFS_SRC, 32'h100);
        apb(1'b1, dtc_pkg::OFS_DST, 32'h200);
        apb(1'b1, dtc_pkg::OFS_CNT, {16'h0, cnt});
        apb(1'b1, dtc_pkg::OFS_FC, 32'h51);
        apb(1'b1, dtc_pkg::OFS_CTRL, {16'h0, ctrl});
        apb(1'b1, dtc_pkg::OFS_SRC, 32'h55);
        q = 32'h1;
        for (int i = 0; i < 200 && q[0] !== 1'b0; i++) apb(1'b0, dtc_pkg::OFS_CTRL, 32'h0);
        chk({31'h0, q[0]}, 32'h0);
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge sys_clk_i);
        mismatches++;
        results;
    end
    // ==========================================
    // scenarios
    initial begin
        repeat (5) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        rchk(dtc_pkg::OFS_CTRL, 32'h0);
        rchk(dtc_pkg::OFS_STAT, 32'h0);
        rchk(8'h3C, 32'h0);
        chk({31'h0, e}, 32'h1);
        wt <= 4'h3;
        run(16'h13E1, 16'h0004);
        rchk(dtc_pkg::OFS_SRC, 32'h104);
        rchk(dtc_pkg::OFS_DST, 32'h204);
        chk(wlast, 20'hB02FD);
        chk(ndone, 1);
        rchk(dtc_pkg::OFS_CNT, 32'h0);
        rchk(dtc_pkg::OFS_STAT, 32'h1);
        chk(nirq, 1);
        apb(1'b1, dtc_pkg::OFS_STAT, 32'h0);
        rchk(dtc_pkg::OFS_STAT, 32'h1);
        apb(1'b1, dtc_pkg::OFS_STAT, 32'h1);
        rchk(dtc_pkg::OFS_STAT, 32'h0);
        run(16'h03C1, 16'h0004);
        rchk(dtc_pkg::OFS_SRC, 32'h108);
        rchk(dtc_pkg::OFS_DST, 32'h204);
        chk(wlast, 20'hBFBF9);
        chk(nirq, 1);
        run(16'h13A1, 16'h0004);
        rchk(dtc_pkg::OFS_SRC, 32'h104);
        rchk(dtc_pkg::OFS_DST, 32'h208);
        chk(wlast, 20'hA00FD);
        run(16'h1381, 16'h0002);
        rchk(dtc_pkg::OFS_SRC, 32'h102);
        run(16'h11E1, 16'h0003);
        rchk(dtc_pkg::OFS_SRC, 32'h103);
        rchk(dtc_pkg::OFS_DST, 32'h203);
        chk(nirq, 4);
        apb(1'b1, dtc_pkg::OFS_STAT, 32'h1);
        erren <= 1'b1;
        run(16'h2381, 16'h0002);
        rchk(dtc_pkg::OFS_STAT, 32'h2);
        chk(eirq, 1);
        apb(1'b1, dtc_pkg::OFS_STAT, 32'h2);
        rchk(dtc_pkg::OFS_STAT, 32'h0);
        // burst from a peripheral that is the source, request held low throughout
        erren <= 1'b0;
        preq_en <= 1'b1;
        run(16'h9385, 16'h0003);
        rchk(dtc_pkg::OFS_SRC, 32'h103);
        chk(nack, 3);
        chk(ndone, 6);
        // peripheral ends the block early through its done line
        pdone_en <= 1'b1;
        run(16'h9385, 16'h0010);
        rchk(dtc_pkg::OFS_CNT, 32'hF);
        rchk(dtc_pkg::OFS_STAT, 32'h9);
        chk(nirq, 6);
        results;
    end
endmodule // dtc_channel_bench
